// >>> hdl/sct_top.sv
// Short-circuit trip logic with its configuration and output control.
// Assumes comparator results, pack-mode select and supply-good come in
// synchronous to clock_i; the watchdog clock is sampled as a level.
`timescale 1ns/1ps
`default_nettype none
`include "sct_cfg.svh"
module sct_top (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic watchdog_clock_in_i,
  input wire logic chg_short_cmp_i,
  input wire logic dsg_short_cmp_i,
  input wire logic pack_mode_select_i,
  input wire logic supply_ok_i,
  output logic [9:0] chg_short_thresh_mv_o,
  output logic [9:0] dsg_short_thresh_mv_o,
  output logic charge_fet_drive_o,
  output logic discharge_fet_drive_o,
  output logic zero_volt_fet_drive_o,
  output logic open_drain_out_o,
  output logic open_drain_out_oe_o,
  output logic chg_short_flag_o
);
  import sct_pkg::*;

  // ---------------------------------------------------------------
  // Decoding
  // ---------------------------------------------------------------
  function automatic logic [9:0] thresh_mv(input logic [3:0] code);
    thresh_mv = `SCT_THR_BASE_MV + `SCT_THR_STEP_MV * {6'd0, code};
  endfunction

  function automatic logic [4:0] delay_ticks(input logic [3:0] code);
    delay_ticks = 5'(`SCT_TICKS_PER_STEP * code);
  endfunction

  sct_core_s q, d;
  sct_regwr_s wr;
  logic [7:0] rd_addr, rd_data;
  logic tick, clr_evt, trip_any;
  logic [1:0] cmp, trip_now;
  logic [1:0][3:0] dly_code;

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  sct_serial u_serial (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .rd_data_i(rd_data),
    .rd_addr_o(rd_addr),
    .wr_o(wr)
  );

  always_comb begin
    rd_data = 8'h00;
    unique case (rd_addr)
      `SCT_ADDR_STATUS: begin
        rd_data[`SCT_ST_CHG_SC] = chg_short_cmp_i;
        rd_data[`SCT_ST_DSG_SC] = dsg_short_cmp_i;
        rd_data[`SCT_ST_FAULT] = q.fault;
      end
      `SCT_ADDR_OUT_CTL: rd_data = {3'd0, q.out_ctl};
      `SCT_ADDR_CHG_SC: rd_data = q.chg_sc;
      `SCT_ADDR_DSG_SC: rd_data = q.dsg_sc;
      default: rd_data = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Blanking timers, one per direction
  // ---------------------------------------------------------------
  // Without watchdog edges the counters stall, so a nonzero delay
  // never expires: protection then relies on the zero-delay code.
  assign tick = watchdog_clock_in_i & ~q.wd_q;
  assign cmp = {dsg_short_cmp_i, chg_short_cmp_i};
  assign dly_code[0] = q.chg_sc[`SCT_DLY_LSB +: 4];
  assign dly_code[1] = q.dsg_sc[`SCT_DLY_LSB +: 4];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_dir
      // Zero code trips in the very cycle of detection
      assign trip_now[g] = cmp[g] & ((dly_code[g] == 4'd0) |
        (q.cnt[g] >= delay_ticks(dly_code[g])));
    end
  endgenerate

  assign trip_any = |trip_now;
  assign clr_evt = q.clr_armed & ~q.out_ctl[`SCT_OC_CLEAR];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.wd_q = watchdog_clock_in_i;
    for (int i = 0; i < 2; i++) begin
      if (!cmp[i]) begin
        d.cnt[i] = 5'd0;
      end else if (tick && q.cnt[i] != 5'h1f) begin
        d.cnt[i] = q.cnt[i] + 5'd1;
      end
    end
    if (wr.wr_en) begin
      unique case (wr.addr)
        `SCT_ADDR_OUT_CTL: d.out_ctl = wr.data[4:0];
        `SCT_ADDR_CHG_SC: d.chg_sc = wr.data;
        `SCT_ADDR_DSG_SC: d.dsg_sc = wr.data;
        default: d.out_ctl = q.out_ctl;
      endcase
    end
    if (q.out_ctl[`SCT_OC_CLEAR]) begin
      d.clr_armed = 1'b1;
    end else if (clr_evt) begin
      d.clr_armed = 1'b0;
    end
    // A new trip outweighs a clear arriving in the same cycle
    d.fault = trip_any | (q.fault & ~clr_evt);
    if (supply_ok_i) begin
      d.boot_hold = 1'b0;
    end
    if (d.fault) begin
      d.chg_drv = 1'b0;
      d.dsg_drv = 1'b0;
      d.zv_drv = 1'b0;
    end else begin
      d.chg_drv = q.boot_hold | q.out_ctl[`SCT_OC_CHG];
      d.dsg_drv = q.out_ctl[`SCT_OC_DSG];
      d.zv_drv = ~q.out_ctl[`SCT_OC_XZV];
    end
  end

  // Reset is synchronous, so the mode pin may be caught here
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      q <= '0;
      q.chg_sc <= `SCT_SC_RESET;
      q.dsg_sc <= `SCT_SC_RESET;
      q.out_ctl[`SCT_OC_CHG] <= pack_mode_select_i;
      q.boot_hold <= pack_mode_select_i;
      q.chg_drv <= pack_mode_select_i;
      q.zv_drv <= 1'b1;
      // Seed with the live level, so a high pin gives no false tick
      q.wd_q <= watchdog_clock_in_i;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign chg_short_thresh_mv_o = thresh_mv(q.chg_sc[`SCT_THR_LSB +: 4]);
  assign dsg_short_thresh_mv_o = thresh_mv(q.dsg_sc[`SCT_THR_LSB +: 4]);
  assign charge_fet_drive_o = q.chg_drv;
  assign discharge_fet_drive_o = q.dsg_drv;
  assign zero_volt_fet_drive_o = q.zv_drv;
  assign open_drain_out_o = 1'b0;
  assign open_drain_out_oe_o = q.out_ctl[`SCT_OC_OPEN_DRAIN];
  assign chg_short_flag_o = chg_short_cmp_i;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_chg_wr;
    @(posedge clock_i) disable iff (!nrst_i)
    wr.wr_en && wr.addr == `SCT_ADDR_CHG_SC |=> q.chg_sc == $past(wr.data);
  endproperty
  a_chg_wr: assert property (p_chg_wr) else $error("chg config lost");

  property p_dsg_wr;
    @(posedge clock_i) disable iff (!nrst_i)
    wr.wr_en && wr.addr == `SCT_ADDR_DSG_SC |=> q.dsg_sc == $past(wr.data);
  endproperty
  a_dsg_wr: assert property (p_dsg_wr) else $error("dsg config lost");

  property p_thr_range;
    @(posedge clock_i) disable iff (!nrst_i)
    chg_short_thresh_mv_o >= 10'd100 && chg_short_thresh_mv_o <= 10'd475 &&
    (chg_short_thresh_mv_o - 10'd100) % 10'd25 == 10'd0;
  endproperty
  a_thr_range: assert property (p_thr_range) else $error("bad threshold");

  property p_zero_dly;
    @(posedge clock_i) disable iff (!nrst_i)
    chg_short_cmp_i && q.chg_sc[7:4] == 4'd0 |=>
      q.fault && !charge_fet_drive_o && !zero_volt_fet_drive_o;
  endproperty
  a_zero_dly: assert property (p_zero_dly) else $error("no instant trip");

  property p_off;
    @(posedge clock_i) disable iff (!nrst_i)
    q.fault |-> !charge_fet_drive_o && !discharge_fet_drive_o &&
      !zero_volt_fet_drive_o;
  endproperty
  a_off: assert property (p_off) else $error("drive on under fault");

  property p_blank;
    @(posedge clock_i) disable iff (!nrst_i)
    $rose(q.fault) |-> $past(trip_any);
  endproperty
  a_blank: assert property (p_blank) else $error("trip without cause");

  property p_hold;
    @(posedge clock_i) disable iff (!nrst_i)
    q.fault && !clr_evt |=> q.fault;
  endproperty
  a_hold: assert property (p_hold) else $error("fault dropped");

  property p_clear;
    @(posedge clock_i) disable iff (!nrst_i)
    q.fault && clr_evt && !trip_any |=> !q.fault;
  endproperty
  a_clear: assert property (p_clear) else $error("clear ignored");

  property p_boot;
    @(posedge clock_i) disable iff (!nrst_i)
    q.boot_hold && !d.fault |=> charge_fet_drive_o;
  endproperty
  a_boot: assert property (p_boot) else $error("boot chg off");

endmodule
`default_nettype wire

// >>> hdl/sct_cfg.svh
// Offsets, field positions, reset values and timing counts of the
// short-circuit trip block. Included by every design file that needs them.
`ifndef SCT_CFG_SVH
`define SCT_CFG_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define SCT_ADDR_STATUS 8'h00
`define SCT_ADDR_OUT_CTL 8'h01
`define SCT_ADDR_CHG_SC 8'h07
`define SCT_ADDR_DSG_SC 8'h08

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define SCT_ST_DSG_SC 0
`define SCT_ST_CHG_SC 1
`define SCT_ST_FAULT 7
`define SCT_OC_CLEAR 0
`define SCT_OC_DSG 1
`define SCT_OC_CHG 2
`define SCT_OC_XZV 3
`define SCT_OC_OPEN_DRAIN 4
`define SCT_SC_RESET 8'h00
`define SCT_THR_LSB 0
`define SCT_DLY_LSB 4

// ---------------------------------------------------------------
// Threshold decode, millivolts
// ---------------------------------------------------------------
`define SCT_THR_BASE_MV 10'd100
`define SCT_THR_STEP_MV 10'd25

// ---------------------------------------------------------------
// Timing: one delay step against the 32 kHz watchdog clock
// ---------------------------------------------------------------
`define SCT_DLY_STEP_NS 61000
`define SCT_WD_PERIOD_NS 30518
`define SCT_TICKS_PER_STEP \
  ((`SCT_DLY_STEP_NS + `SCT_WD_PERIOD_NS - 1) / `SCT_WD_PERIOD_NS)

// ---------------------------------------------------------------
// Serial port
// ---------------------------------------------------------------
`define SCT_DEV_ADDR 7'h2a

`endif

// >>> hdl/sct_pkg.sv
// Types shared by the short-circuit trip block and its serial port.
// Assumes the constants header is compiled alongside.
package sct_pkg;

  typedef enum logic [5:0] {
    SER_IDLE = 6'b000001,
    SER_RX = 6'b000010,
    SER_ACK = 6'b000100,
    SER_TX = 6'b001000,
    SER_RACK = 6'b010000,
    SER_LOAD = 6'b100000
  } sct_ser_e;

  typedef struct packed {
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] data;
  } sct_regwr_s;

  typedef struct packed {
    sct_ser_e st;
    logic [2:0] bitcnt;
    logic [7:0] shreg;
    logic [1:0] phase;
    logic rw;
    logic [7:0] ptr;
    logic sda_oe;
    logic scl_q;
    logic sda_q;
    logic wr_en;
    logic [7:0] wr_data;
  } sct_ser_s;

  typedef struct packed {
    logic [4:0] out_ctl;
    logic [7:0] chg_sc;
    logic [7:0] dsg_sc;
    logic wd_q;
    logic [1:0][4:0] cnt;
    logic fault;
    logic clr_armed;
    logic boot_hold;
    logic chg_drv;
    logic dsg_drv;
    logic zv_drv;
  } sct_core_s;

endpackage

// >>> hdl/sct_serial.sv
// Two-wire serial register port: device address, register pointer,
// then data bytes written or read with pointer auto-increment.
// Assumes scl and sda are already synchronous to clock_i.
`timescale 1ns/1ps
`default_nettype none
`include "sct_cfg.svh"
module sct_serial (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [7:0] rd_data_i,
  output logic [7:0] rd_addr_o,
  output sct_pkg::sct_regwr_s wr_o
);
  import sct_pkg::*;

  sct_ser_s q, d;
  logic rise, fall, start, stop;

  assign rise = scl_i & ~q.scl_q;
  assign fall = ~scl_i & q.scl_q;
  assign start = scl_i & q.scl_q & q.sda_q & ~sda_i;
  assign stop = scl_i & q.scl_q & ~q.sda_q & sda_i;

  always_comb begin
    d = q;
    d.scl_q = scl_i;
    d.sda_q = sda_i;
    d.wr_en = 1'b0;
    if (start) begin
      d.st = SER_RX;
      d.bitcnt = 3'd0;
      d.phase = 2'd0;
      d.sda_oe = 1'b0;
    end else if (stop) begin
      d.st = SER_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      unique case (q.st)
        SER_IDLE: d.sda_oe = 1'b0;
        SER_RX: begin
          if (rise) begin
            d.shreg = {q.shreg[6:0], sda_i};
            d.bitcnt = q.bitcnt + 3'd1;
          end
          if (rise && q.bitcnt == 3'd7) begin
            d.st = SER_ACK;
          end
        end
        SER_ACK: begin
          // Byte is complete; acknowledge on the following low phase
          if (fall && !q.sda_oe) begin
            if (q.phase == 2'd0 && q.shreg[7:1] != `SCT_DEV_ADDR) begin
              d.st = SER_IDLE;
            end else begin
              d.sda_oe = 1'b1;
              if (q.phase == 2'd0) begin
                d.rw = q.shreg[0];
              end else if (q.phase == 2'd1) begin
                d.ptr = q.shreg;
              end else begin
                d.wr_en = 1'b1;
                d.wr_data = q.shreg;
              end
            end
          end else if (fall) begin
            d.sda_oe = 1'b0;
            d.bitcnt = 3'd0;
            if (q.phase == 2'd2) begin
              d.ptr = q.ptr + 8'd1;
            end
            if (q.phase == 2'd0 && q.rw) begin
              d.st = SER_TX;
              d.shreg = rd_data_i;
              d.sda_oe = ~rd_data_i[7];
            end else begin
              d.st = SER_RX;
              d.phase = (q.phase == 2'd0) ? 2'd1 : 2'd2;
            end
          end
        end
        SER_TX: begin
          if (fall) begin
            if (q.bitcnt == 3'd7) begin
              d.st = SER_RACK;
              d.sda_oe = 1'b0;
            end else begin
              d.bitcnt = q.bitcnt + 3'd1;
              d.shreg = {q.shreg[6:0], 1'b0};
              d.sda_oe = ~q.shreg[6];
            end
          end
        end
        SER_RACK: begin
          if (rise) begin
            d.st = sda_i ? SER_IDLE : SER_LOAD;
            d.ptr = sda_i ? q.ptr : q.ptr + 8'd1;
          end
        end
        SER_LOAD: begin
          if (fall) begin
            d.st = SER_TX;
            d.bitcnt = 3'd0;
            d.shreg = rd_data_i;
            d.sda_oe = ~rd_data_i[7];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      q <= '{st: SER_IDLE, scl_q: 1'b1, sda_q: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = q.sda_oe;
  assign rd_addr_o = q.ptr;
  assign wr_o = '{wr_en: q.wr_en, addr: q.ptr, data: q.wr_data};

endmodule
`default_nettype wire

// >>> sim/sct_host.sv
// Host controller model: bit-level master on the two-wire register port.
// Assumes a pull-up resolves the shared data line outside this module.
`timescale 1ns/1ps
`default_nettype none
`include "sct_cfg.svh"
module sct_host (
  input wire logic clock_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  int nacks = 0;
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // Data only moves while the clock line is low, else it frames
  task automatic bx(input logic b, output logic r);
    sda_oe_o <= ~b;
    tk(2);
    scl_o <= 1'b1;
    tk(3);
    r = sda_i;
    tk(1);
    scl_o <= 1'b0;
    tk(2);
  endtask
  task automatic start();
    @(posedge clock_i);
    sda_oe_o <= 1'b0;
    tk(2);
    scl_o <= 1'b1;
    tk(3);
    sda_oe_o <= 1'b1;
    tk(3);
    scl_o <= 1'b0;
    tk(2);
  endtask
  task automatic stop();
    sda_oe_o <= 1'b1;
    tk(2);
    scl_o <= 1'b1;
    tk(3);
    sda_oe_o <= 1'b0;
    tk(3);
  endtask
  task automatic sb(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bx(d[i], r);
    bx(1'b1, r);
    if (r !== 1'b0) nacks++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input bit two);
    start();
    sb({`SCT_DEV_ADDR, 1'b0});
    sb(a);
    if (two) sb(d[15:8]);
    sb(d[7:0]);
    stop();
  endtask
  // Pointer write, repeated start, one byte read, then no acknowledge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic r;
    start();
    sb({`SCT_DEV_ADDR, 1'b0});
    sb(a);
    start();
    sb({`SCT_DEV_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) bx(1'b1, d[i]);
    bx(1'b1, r);
    stop();
  endtask
endmodule
`default_nettype wire

// >>> sim/sct_top_test.sv
// Self-checking bench for the short-circuit trip block.
// Assumes the design package, header and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module sct_top_test;
  import sct_pkg::*;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic wd = 1'b0, wd_en = 1'b1, ccmp = 1'b0, dcmp = 1'b0;
  logic pack_mode = 1'b0, sok = 1'b1;
  logic scl, h_oe, d_oe, sda, charge_fet_drive, discharge_fet_drive, zv, odo, flag;
  logic [9:0] cthr, dthr;
  logic [8:0] wd_cnt = 9'h000;
  logic [7:0] v;
  logic [15:0] w;
  int bad_count = 0, compares = 0, seed = 63, n;
  always #25 clock_i = ~clock_i;
  // Open-drain data line with pull-up
  assign sda = ~(h_oe | d_oe);
  // --------------------------------------------
  // Watchdog clock, 610 cycles a period
  // --------------------------------------------
  always @(posedge clock_i) begin
    if (wd_en) begin
      wd_cnt <= (wd_cnt == 9'h130) ? 9'h000 : wd_cnt + 9'h001;
      if (wd_cnt == 9'h130) wd <= ~wd;
    end
  end
  sct_top uut (.clock_i(clock_i), .nrst_i(nrst_i), .scl_i(scl),
    .sda_i(sda), .sda_o(), .sda_oe_o(d_oe), .watchdog_clock_in_i(wd),
    .chg_short_cmp_i(ccmp), .dsg_short_cmp_i(dcmp),
    .pack_mode_select_i(pack_mode), .supply_ok_i(sok),
    .chg_short_thresh_mv_o(cthr), .dsg_short_thresh_mv_o(dthr),
    .charge_fet_drive_o(charge_fet_drive), .discharge_fet_drive_o(discharge_fet_drive),
    .zero_volt_fet_drive_o(zv), .open_drain_out_o(),
    .open_drain_out_oe_o(odo), .chg_short_flag_o(flag));
  sct_host host (.clock_i(clock_i), .sda_i(sda), .scl_o(scl),
    .sda_oe_o(h_oe));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  function automatic logic [9:0] mv(input logic [3:0] c);
    return 10'h064 + 10'h019 * {6'h00, c};
  endfunction
  task automatic give_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clock_i);
  endtask
  task automatic do_reset();
    nrst_i <= 1'b0;
    cyc(8);
    nrst_i <= 1'b1;
    cyc(1);
  endtask
  // Bounded wait for a rising watchdog level
  task automatic wd_rise();
    logic p;
    p = wd;
    for (int k = 0; k < 1000; k++) begin
      @(posedge clock_i);
      #1;
      if (wd && !p) return;
      p = wd;
    end
    bad_count++;
    give_verdict();
  endtask
  // --------------------------------------------
  // Main sequence
  // --------------------------------------------
  initial begin
    do_reset();
    #1;
    chk(16'({charge_fet_drive, discharge_fet_drive, zv, odo}), 16'h0002);
    host.rd(8'h07, v);
    chk(16'(v), 16'h0000);
    host.rd(8'h08, v);
    chk(16'(v), 16'h0000);
    host.rd(8'h09, v);
    chk(16'(v), 16'h0000);
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($random(seed));
      host.wr(8'h07, w, 1'b1);
      host.rd(8'h07, v);
      chk(16'(v), 16'(w[15:8]));
      host.rd(8'h08, v);
      chk(16'(v), 16'(w[7:0]));
      chk(16'(cthr), 16'(mv(w[11:8])));
      chk(16'(dthr), 16'(mv(w[3:0])));
    end
    host.wr(8'h07, 16'h000a, 1'b0);
    host.wr(8'h01, 16'h0016, 1'b0);
    host.wr(8'h01, 16'h001e, 1'b0);
    cyc(1);
    #1;
    chk(16'({charge_fet_drive, discharge_fet_drive, zv, odo}), 16'h000d);
    @(posedge clock_i);
    ccmp <= 1'b1;
    cyc(2);
    #1;
    chk(16'({flag, charge_fet_drive, discharge_fet_drive, zv}), 16'h0008);
    host.rd(8'h00, v);
    chk(16'(v & 8'h82), 16'h0082);
    @(posedge clock_i);
    ccmp <= 1'b0;
    cyc(4);
    #1;
    chk(16'({flag, charge_fet_drive, discharge_fet_drive, zv}), 16'h0000);
    host.wr(8'h01, 16'h001f, 1'b0);
    host.wr(8'h01, 16'h001e, 1'b0);
    cyc(2);
    #1;
    chk(16'({charge_fet_drive, discharge_fet_drive, zv}), 16'h0006);
    n = 1 + ({$random(seed)} % 3);
    host.wr(8'h08, 16'(n << 4), 1'b0);
    // Stopped watchdog: a nonzero delay never runs out
    @(posedge clock_i);
    wd_en <= 1'b0;
    dcmp <= 1'b1;
    cyc(3000);
    #1;
    chk(16'(discharge_fet_drive), 16'h0001);
    @(posedge clock_i);
    dcmp <= 1'b0;
    wd_en <= 1'b1;
    // Short pulse first, so a counter that is not cleared trips early
    wd_rise();
    @(posedge clock_i);
    dcmp <= 1'b1;
    wd_rise();
    @(posedge clock_i);
    dcmp <= 1'b0;
    wd_rise();
    @(posedge clock_i);
    dcmp <= 1'b1;
    for (int k = 1; k < 2 * n; k++) wd_rise();
    cyc(3);
    #1;
    chk(16'(discharge_fet_drive), 16'h0001);
    wd_rise();
    cyc(3);
    #1;
    chk(16'({charge_fet_drive, discharge_fet_drive, zv}), 16'h0000);
    @(posedge clock_i);
    dcmp <= 1'b0;
    pack_mode <= 1'b1;
    sok <= 1'b0;
    do_reset();
    #1;
    chk(16'({charge_fet_drive, zv}), 16'h0003);
    host.wr(8'h01, 16'h0000, 1'b0);
    cyc(2);
    #1;
    chk(16'(charge_fet_drive), 16'h0001);
    @(posedge clock_i);
    sok <= 1'b1;
    cyc(3);
    #1;
    chk(16'(charge_fet_drive), 16'h0000);
    host.wr(8'h01, 16'h0004, 1'b0);
    cyc(2);
    #1;
    chk(16'(charge_fet_drive), 16'h0001);
    chk(16'(host.nacks), 16'h0000);
    give_verdict();
  end
endmodule
`default_nettype wire
